// ===== inc/pdsir_regs.svh
// Register offsets, field positions, reset values of the port diag/status/event bank
`ifndef PDSIR_REGS_SVH
`define PDSIR_REGS_SVH

// Register addresses (5-bit PHY register numbers)
`define PDSIR_OFS_DIAG 5'h12
`define PDSIR_OFS_LINK 5'h13
`define PDSIR_OFS_SYMERR 5'h15
`define PDSIR_OFS_EVT 5'h1b
`define PDSIR_OFS_PHYCTL 5'h1f

// Cable diagnostic control/result fields
`define PDSIR_DIAG_RUN_BIT 15
`define PDSIR_DIAG_RSVD_HI_MSB 14
`define PDSIR_DIAG_RSVD_HI_LSB 13
`define PDSIR_DIAG_PAIR_BIT 12
`define PDSIR_DIAG_RSVD_LO_MSB 11
`define PDSIR_DIAG_RSVD_LO_LSB 10
`define PDSIR_DIAG_RES_MSB 9
`define PDSIR_DIAG_RES_LSB 8

// Cable diagnostic result codes
`define PDSIR_RES_NORMAL 2'h0
`define PDSIR_RES_OPEN 2'h1
`define PDSIR_RES_SHORT 2'h2

// Link status, event enables/flags, jabber enable positions
`define PDSIR_LINK_BIT 0
`define PDSIR_EVT_EN_MSB 15
`define PDSIR_EVT_EN_LSB 8
`define PDSIR_EVT_FLG_MSB 7
`define PDSIR_EVT_FLG_LSB 0
`define PDSIR_JAB_EN_BIT 9

// Reset values, counter saturation limit and zero read data
`define PDSIR_RST_PAIR 1'h0
`define PDSIR_RST_RES 2'h0
`define PDSIR_RST_SYMERR 16'h0000
`define PDSIR_RST_EVT_EN 8'h00
`define PDSIR_RST_EVT_FLG 8'h00
`define PDSIR_RST_JAB_EN 1'h1
`define PDSIR_CNT_MAX 16'hffff
`define PDSIR_RD_ZERO 16'h0000

`endif

// ===== inc/pdsir_pkg.sv
// Types shared by the port diag/status/event register bank
`include "pdsir_regs.svh"

package pdsir_pkg;

    // Register access request from the management side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pdsir_req_t;

    // Event pulses from the PHY core
    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic par_fault;
        logic lp_ack;
        logic remote_fault;
    } pdsir_evt_t;

    // All state of the top module except the event flags kept in pdsir_flag
    typedef struct packed {
        logic diag_run;
        logic diag_pair;
        logic [1:0] diag_rsvd_hi;
        logic [1:0] diag_rsvd_lo;
        logic [1:0] diag_result;
        logic [15:0] sym_err_cnt;
        logic [7:0] evt_en;
        logic jab_en;
        logic link_prev;
        logic [15:0] rdata;
        logic rvalid;
        logic irq;
    } pdsir_state_t;

endpackage

// ===== logic/pdsir_flag.sv
// Sticky event flag vector, set wins over a simultaneous clear
`timescale 1ns/1ps
`default_nettype none

module pdsir_flag #(
    parameter int W = 8
) (
    input wire logic clk_i,            // System clock
    input wire logic rst_n_i,          // Synchronous reset, active low
    input wire logic ce_i,             // Clock enable, freezes state
    input wire logic [W-1:0] set_i,    // Per-bit set pulses
    input wire logic clr_i,            // Clear all, one-cycle pulse
    output logic [W-1:0] q_o           // Flag values from flops
);

    logic [W-1:0] next_q;

    // Set wins so an event during the clearing read is kept
    always_comb begin
        next_q = clr_i ? set_i : (q_o | set_i);
    end

    // Flag storage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_o <= '0;
        end else if (ce_i) begin
            q_o <= next_q;
        end
    end

endmodule

`default_nettype wire

// ===== logic/pdsir_top.sv
// Per-port cable diagnostic, link status, symbol error count and event register bank
//
// Operation
// RULE_01: Writing one to the test enable bit starts a cable test that self-clears at the end, writing zero stops it.
// RULE_02: The test enable bit reads one while a test runs and zero once it ends with a valid result.
// RULE_03: The pair select bit picks the transmit pair at zero or the receive pair at one, reset zero.
// RULE_04: The read-only result field shows 00 normal, 01 open, 10 short, 11 reserved, reset 00.
// RULE_05: The lowest bit of the link status register reads one while the 100 Mb/s link is up.
// RULE_06: A sixteen-bit counter counts received frames with symbol errors, clears on read, resets to zero.
// RULE_07: Bits 15 to 8 of the event register are read/write enables in the fixed source order, reset zero.
// RULE_08: Bits 7 to 3 are flags for jabber, receive error, page received, parallel detect fault, partner ack.
// RULE_09: Bit 2 is set when the port link goes down.
// RULE_10: Bit 1 is set when a remote fault occurs.
// RULE_11: Bit 0 is set when the port link comes up.
// RULE_12: All event flags reset to zero and are cleared when the host reads the event register.
// RULE_13: Jabber events are counted only while the jabber enable bit is one, which resets to one.
// RULE_14: The interrupt request is high while any flag is set together with its enable bit.
`timescale 1ns/1ps
`default_nettype none

module pdsir_top
    import pdsir_pkg::*;
(
    input wire logic clk_i,               // System clock, 25 MHz
    input wire logic rst_n_i,             // Synchronous reset, active low
    input wire logic ce_i,                // Clock enable, freezes state when low
    input wire pdsir_req_t reg_req_i,     // Register read/write request
    output logic [15:0] reg_rdata_o,      // Read data, held until next read
    output logic reg_rvalid_o,            // Read data valid pulse
    input wire logic link_up_i,           // 100 Mb/s link level
    input wire logic sym_err_frame_i,     // Frame with symbol errors, pulse
    input wire pdsir_evt_t evt_i,         // PHY core event pulses
    input wire logic diag_done_i,         // Cable test finished, pulse
    input wire logic [1:0] diag_result_i, // Cable test outcome with done
    output logic diag_run_o,              // Cable test request/in progress
    output logic diag_pair_o,             // Pair under test, 1 = receive pair
    output logic jabber_en_o,             // Jabber counter enable
    output logic link_status_o,           // Registered link level
    output logic irq_o                    // Port interrupt request
);

    localparam pdsir_state_t ST_RST = '{
        diag_run: 1'b0,
        diag_pair: `PDSIR_RST_PAIR,
        diag_rsvd_hi: 2'h0,
        diag_rsvd_lo: 2'h0,
        diag_result: `PDSIR_RST_RES,
        sym_err_cnt: `PDSIR_RST_SYMERR,
        evt_en: `PDSIR_RST_EVT_EN,
        jab_en: `PDSIR_RST_JAB_EN,
        link_prev: 1'b0,
        rdata: `PDSIR_RD_ZERO,
        rvalid: 1'b0,
        irq: 1'b0
    };

    pdsir_state_t s;
    pdsir_state_t next_s;
    logic [7:0] flags;
    logic [7:0] flag_set;
    logic flag_clr;
    logic link_went_up;
    logic link_went_down;
    logic wr_diag;
    logic wr_evt;
    logic wr_ctl;
    logic rd_cnt;
    logic [15:0] rd_mux;

    // Register decode
    assign wr_diag = reg_req_i.wr && (reg_req_i.addr == `PDSIR_OFS_DIAG);
    assign wr_evt = reg_req_i.wr && (reg_req_i.addr == `PDSIR_OFS_EVT);
    assign wr_ctl = reg_req_i.wr && (reg_req_i.addr == `PDSIR_OFS_PHYCTL);
    assign rd_cnt = reg_req_i.rd && (reg_req_i.addr == `PDSIR_OFS_SYMERR);

    // Link edges against the previous sample; reset level is down
    assign link_went_up = link_up_i && !s.link_prev;
    assign link_went_down = !link_up_i && s.link_prev;

    // Event flag sources in register bit order
    always_comb begin
        flag_set = 8'h00;
        // RULE_13: jabber gated by enable
        flag_set[7] = evt_i.jabber && s.jab_en;
        // RULE_08: core event flags
        flag_set[6] = evt_i.rx_error;
        flag_set[5] = evt_i.page_rx;
        flag_set[4] = evt_i.par_fault;
        flag_set[3] = evt_i.lp_ack;
        // RULE_09: link down flag
        flag_set[2] = link_went_down;
        // RULE_10: remote fault flag
        flag_set[1] = evt_i.remote_fault;
        // RULE_11: link up flag
        flag_set[0] = link_went_up;
    end

    // RULE_12: read of event register clears
    assign flag_clr = reg_req_i.rd && (reg_req_i.addr == `PDSIR_OFS_EVT);

    pdsir_flag #(
        .W(8)
    ) u_flags (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .q_o(flags)
    );

    // Read data selection; unmapped addresses read as zero
    always_comb begin
        rd_mux = `PDSIR_RD_ZERO;
        case (reg_req_i.addr)
            `PDSIR_OFS_DIAG: begin
                // RULE_02: enable bit reads busy state
                rd_mux[`PDSIR_DIAG_RUN_BIT] = s.diag_run;
                rd_mux[`PDSIR_DIAG_RSVD_HI_MSB:`PDSIR_DIAG_RSVD_HI_LSB] = s.diag_rsvd_hi;
                rd_mux[`PDSIR_DIAG_PAIR_BIT] = s.diag_pair;
                rd_mux[`PDSIR_DIAG_RSVD_LO_MSB:`PDSIR_DIAG_RSVD_LO_LSB] = s.diag_rsvd_lo;
                // RULE_04: result field readback
                rd_mux[`PDSIR_DIAG_RES_MSB:`PDSIR_DIAG_RES_LSB] = s.diag_result;
            end
            `PDSIR_OFS_LINK: begin
                // RULE_05: live link level
                rd_mux[`PDSIR_LINK_BIT] = link_up_i;
            end
            `PDSIR_OFS_SYMERR: begin
                rd_mux = s.sym_err_cnt;
            end
            `PDSIR_OFS_EVT: begin
                rd_mux[`PDSIR_EVT_EN_MSB:`PDSIR_EVT_EN_LSB] = s.evt_en;
                rd_mux[`PDSIR_EVT_FLG_MSB:`PDSIR_EVT_FLG_LSB] = flags;
            end
            `PDSIR_OFS_PHYCTL: begin
                rd_mux[`PDSIR_JAB_EN_BIT] = s.jab_en;
            end
            default: begin
                rd_mux = `PDSIR_RD_ZERO;
            end
        endcase
    end

    // Next state of the bank except the event flags
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.link_prev = link_up_i;

        // Read capture; data stays until the next read
        if (reg_req_i.rd) begin
            next_s.rdata = rd_mux;
            next_s.rvalid = 1'b1;
        end

        // RULE_01: test ends by itself on done
        if (s.diag_run && diag_done_i) begin
            next_s.diag_run = 1'b0;
            // RULE_04: latch outcome at completion
            next_s.diag_result = diag_result_i;
        end

        // A host write after done in the same cycle still wins
        if (wr_diag) begin
            // RULE_03: pair select stored
            next_s.diag_pair = reg_req_i.wdata[`PDSIR_DIAG_PAIR_BIT];
            next_s.diag_rsvd_hi = reg_req_i.wdata[`PDSIR_DIAG_RSVD_HI_MSB:`PDSIR_DIAG_RSVD_HI_LSB];
            next_s.diag_rsvd_lo = reg_req_i.wdata[`PDSIR_DIAG_RSVD_LO_MSB:`PDSIR_DIAG_RSVD_LO_LSB];
            // RULE_01: one starts, zero aborts
            if (reg_req_i.wdata[`PDSIR_DIAG_RUN_BIT]) begin
                next_s.diag_run = 1'b1;
                next_s.diag_result = `PDSIR_RES_NORMAL;
            end else begin
                next_s.diag_run = 1'b0;
            end
        end

        // RULE_06: count, clear on read, count wins
        if (rd_cnt) begin
            next_s.sym_err_cnt = `PDSIR_RST_SYMERR;
        end
        if (sym_err_frame_i) begin
            // Saturates so a busy port never wraps to a small value
            if (next_s.sym_err_cnt != `PDSIR_CNT_MAX) begin
                next_s.sym_err_cnt = next_s.sym_err_cnt + 16'h0001;
            end
        end

        // RULE_07: enable bits writable
        if (wr_evt) begin
            next_s.evt_en = reg_req_i.wdata[`PDSIR_EVT_EN_MSB:`PDSIR_EVT_EN_LSB];
        end

        // RULE_13: jabber enable writable
        if (wr_ctl) begin
            next_s.jab_en = reg_req_i.wdata[`PDSIR_JAB_EN_BIT];
        end

        // RULE_14: masked flags drive request
        next_s.irq = |(flags & s.evt_en);
    end

    // Single state register; reset beats the clock enable
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= ST_RST;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o = s.rdata;
    assign reg_rvalid_o = s.rvalid;
    assign diag_run_o = s.diag_run;
    assign diag_pair_o = s.diag_pair;
    assign jabber_en_o = s.jab_en;
    // Edge detector sample doubles as the delayed link level
    assign link_status_o = s.link_prev;
    assign irq_o = s.irq;

endmodule

`default_nettype wire

// ===== testbench/pdsir_top_asserts.sv
// Port-level assertions for the diag/status/event register bank
`timescale 1ns/1ps
`default_nettype none
module pdsir_top_asserts
    import pdsir_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic ce_i, // Clock enable
    input wire pdsir_req_t reg_req_i, // Register request
    input wire logic [15:0] reg_rdata_o, // Read data
    input wire logic reg_rvalid_o, // Read valid
    input wire logic link_up_i, // Link level
    input wire logic sym_err_frame_i, // Error frame pulse
    input wire pdsir_evt_t evt_i, // Event pulses
    input wire logic diag_done_i, // Test done
    input wire logic diag_run_o, // Test running
    input wire logic diag_pair_o, // Pair select
    input wire logic jabber_en_o, // Jabber enable
    input wire logic irq_o // Interrupt
);
    logic rd_t;
    logic wr_t;
    logic [4:0] a;
    // Strobes count only while enabled
    assign rd_t = ce_i && reg_req_i.rd;
    assign wr_t = ce_i && reg_req_i.wr;
    assign a = reg_req_i.addr;
    // One domain, muted in reset
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_RD_ANSWER: assert property (rd_t |=> reg_rvalid_o)
        else $error("read not answered");
    AST_LINK_RD: assert property (
        rd_t && a == 5'h13 |=> reg_rdata_o == {15'h0000, $past(link_up_i)})
        else $error("link status read wrong");
    AST_DIAG_START: assert property (
        wr_t && a == 5'h12 && reg_req_i.wdata[15] |=> diag_run_o)
        else $error("test did not start");
    AST_DIAG_ABORT: assert property (
        wr_t && a == 5'h12 && !reg_req_i.wdata[15] |=> !diag_run_o)
        else $error("test did not stop");
    AST_DIAG_DONE: assert property (
        ce_i && diag_run_o && diag_done_i && !(wr_t && a == 5'h12) |=> !diag_run_o)
        else $error("test bit not self-cleared");
    AST_PAIR: assert property (
        wr_t && a == 5'h12 |=> diag_pair_o == $past(reg_req_i.wdata[12]))
        else $error("pair select wrong");
    AST_JAB_EN: assert property (
        wr_t && a == 5'h1f |=> jabber_en_o == $past(reg_req_i.wdata[9]))
        else $error("jabber enable wrong");
    AST_IRQ: assert property (
        rd_t && a == 5'h1b |=> irq_o == |(reg_rdata_o[15:8] & reg_rdata_o[7:0]))
        else $error("interrupt request wrong");
    AST_SYMERR_CLR: assert property (
        rd_t && a == 5'h15 && !sym_err_frame_i ##1 ce_i && !sym_err_frame_i
        ##1 rd_t && a == 5'h15 |=> reg_rdata_o == 16'h0000)
        else $error("counter not cleared by read");
    AST_FLAG_REMOTE: assert property (
        evt_i.remote_fault && ce_i ##1 ce_i && !reg_req_i.rd ##1 rd_t && a == 5'h1b
        |=> reg_rdata_o[1])
        else $error("remote fault flag missing");
endmodule
bind pdsir_top pdsir_top_asserts chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .link_up_i(link_up_i),
    .sym_err_frame_i(sym_err_frame_i), .evt_i(evt_i), .diag_done_i(diag_done_i),
    .diag_run_o(diag_run_o), .diag_pair_o(diag_pair_o), .jabber_en_o(jabber_en_o),
    .irq_o(irq_o)
);
`default_nettype wire

// ===== testbench/pdsir_tester_model.sv
// Cable tester stand-in answering test requests after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module pdsir_tester_model #(
    parameter int DLY = 8
) (
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic run_i, // Test request level
    input wire logic [1:0] code_i, // Outcome to report
    output logic done_o, // Finished pulse
    output logic [1:0] res_o // Outcome, valid with done only
);
    int cnt;
    // one done pulse per request, dropped on abort
    always @(posedge clk_i) begin
        if (!rst_n_i || !run_i || done_o) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            done_o <= (cnt == DLY);
        end
    end
    // Outcome lines garbled outside the pulse
    assign res_o = done_o ? code_i : ~code_i;
endmodule
`default_nettype wire

// ===== testbench/pdsir_top_bench.sv
// Self-checking bench for the diag/status/event register bank
`timescale 1ns/1ps
`default_nettype none
module pdsir_top_bench
    import pdsir_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    pdsir_req_t req = '0;
    pdsir_evt_t evt = '0;
    logic link = 1'b0;
    logic sym = 1'b0;
    logic [1:0] code = 2'h0;
    logic [1:0] res;
    logic [15:0] rdata;
    logic rvalid, done, run, pair, jab, irq;
    logic lstat;
    int err_count = 0;
    int cmp_count = 0;
    pdsir_top dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .link_up_i(link),
        .sym_err_frame_i(sym), .evt_i(evt), .diag_done_i(done), .diag_result_i(res),
        .diag_run_o(run), .diag_pair_o(pair), .jabber_en_o(jab), .link_status_o(lstat),
        .irq_o(irq)
    );
    pdsir_tester_model #(.DLY(8)) tst_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .code_i(code), .done_o(done),
        .res_o(res)
    );
    // 25 MHz clock
    always #20 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Strobe held for exactly one taking edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i) req <= {1'b0, 1'b1, a, d};
        @(posedge clk_i) req <= '0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_i) req <= {1'b1, 1'b0, a, 16'h0000};
        @(posedge clk_i) req <= '0;
        #1;
        chk("rvalid", 16'h0001, {15'h0000, rvalid});
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic pulse(input pdsir_evt_t v);
        @(posedge clk_i) evt <= v;
        @(posedge clk_i) evt <= '0;
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(5'h12, 16'h0000);
        rd(5'h15, 16'h0000);
        rd(5'h1b, 16'h0000);
        rd(5'h1f, 16'h0200);
        wr(5'h13, 16'hffff);
        rd(5'h13, 16'h0000);
        rd(5'h10, 16'h0000);
        @(posedge clk_i) link <= 1'b1;
        rd(5'h13, 16'h0001);
        chk("link_status", 16'h0001, {15'h0000, lstat});
        rd(5'h1b, 16'h0001);
        rd(5'h1b, 16'h0000);
        @(posedge clk_i) link <= 1'b0;
        rd(5'h1b, 16'h0004);
        chk("link_status", 16'h0000, {15'h0000, lstat});
        // Each source lands in its own flag
        for (int k = 0; k < 6; k++) begin
            pulse(pdsir_evt_t'(6'h01 << k));
            rd(5'h1b, 16'h0001 << (k == 0 ? 1 : k + 2));
        end
        wr(5'h1f, 16'h0000);
        chk("jabber_en", 16'h0000, {15'h0000, jab});
        pulse(pdsir_evt_t'(6'h20));
        rd(5'h1b, 16'h0000);
        wr(5'h1f, 16'h0200);
        // Flag bits ignore writes, enables drive the request
        wr(5'h1b, 16'h55ff);
        rd(5'h1b, 16'h5500);
        wr(5'h1b, 16'hff00);
        pulse(pdsir_evt_t'(6'h10));
        repeat (2) @(posedge clk_i);
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        rd(5'h1b, 16'hff40);
        repeat (2) @(posedge clk_i);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        repeat (3) begin
            @(posedge clk_i) sym <= 1'b1;
            @(posedge clk_i) sym <= 1'b0;
        end
        rd(5'h15, 16'h0003);
        rd(5'h15, 16'h0000);
        // Outcome codes normal, open and short on the receive pair
        for (int c = 0; c < 3; c++) begin
            code <= 2'(c);
            wr(5'h12, 16'h9000);
            chk("pair", 16'h0001, {15'h0000, pair});
            rd(5'h12, 16'h9000);
            for (int n = 0; n < 50 && run; n++) @(posedge clk_i);
            rd(5'h12, 16'h1000 | (16'(c) << 8));
        end
        // Abort before the tester answers
        wr(5'h12, 16'h8000);
        chk("pair", 16'h0000, {15'h0000, pair});
        wr(5'h12, 16'h0000);
        chk("run", 16'h0000, {15'h0000, run});
        rd(5'h12, 16'h0000);
        // Result field ignores writes, spare bits are plain storage
        wr(5'h12, 16'h6f00);
        rd(5'h12, 16'h6c00);
        // Enable low must freeze flags and counter alike
        @(posedge clk_i) ce_i <= 1'b0;
        pulse(pdsir_evt_t'(6'h01));
        @(posedge clk_i) sym <= 1'b1;
        @(posedge clk_i) sym <= 1'b0;
        @(posedge clk_i) ce_i <= 1'b1;
        rd(5'h1b, 16'hff00);
        rd(5'h15, 16'h0000);
        // Reset with no test running puts the diag, event and jabber fields back to their reset values
        wr(5'h12, 16'h7c00);
        wr(5'h1f, 16'h0000);
        @(posedge clk_i) rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(5'h12, 16'h0000);
        chk("pair", 16'h0000, {15'h0000, pair});
        rd(5'h1b, 16'h0000);
        rd(5'h1f, 16'h0200);
        chk("jabber_en", 16'h0001, {15'h0000, jab});
        results();
    end
    // Watchdog, far beyond the fewer than two hundred cycles needed
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
